// ===== core/ipn_priority_nesting_ctrl.sv
/*
 * Interrupt priority nesting controller: per-source levels, mask
 * comparison, vector-fetch mask push and software pull, over APB.
 * Assumes synchronous source requests and a vector fetch pulse with the
 * index of the source being vectored, all on core_clk_in.
 */
// What this block does
// - Each source holds a two-bit level, three highest, zero lowest.
// - Software may read and write source levels at any time.
// - When enabled, a request passes only if level is at least mask.
// - In stop3 mode the comparison uses zero instead of the mask.
// - When disabled, each request passes straight to the CPU.
// - Levels do not alter the CPU's own fixed arbitration order.
// - When enabled, on vector fetch the mask loads the vectored source's level.
// - The old mask shifts into a four-entry pseudo stack on an enabled fetch.
// - Writing one to pull restores mask from the newest stack entry.
// - Full flag sets once the last stack position is written.
// - Empty flag sets once every stored value has been pulled.
// - Current mask sits in the low two control register bits.
// - Only synchronous requests enter; wake-up signals bypass it.
// - A masked pin request still shows its level for branch tests.
// - Nesting while full discards the oldest, lowest stack entry.
// - Each pull shifts zeros into stack bits one and zero.
// - Mask writes never push; a simultaneous fetch wins over a pull when enabled.
`include "ipn_defines.svh"

module ipn_priority_nesting_ctrl
    import ipn_pkg::*;
(
    // Clock and reset.
    input  wire logic                      core_clk_in,
    input  wire logic                      reset_in,
    // APB slave.
    input  wire ipn_apb_req_s              apb_req_in,
    output ipn_apb_rsp_s                   apb_rsp_out,
    // Interrupt sources and CPU side.
    input  wire logic [`IPN_NUM_SRC-1:0]   src_request_in,
    input  wire logic                      vector_fetch_in,
    input  wire logic [3:0]                vector_src_in,
    input  wire logic                      pin_level_in,
    output logic      [`IPN_NUM_SRC-1:0]   cpu_request_out,
    output logic                           pin_level_out,
    // Event interrupt.
    output logic                           irq_out
);

    ipn_state_s s_q;
    ipn_state_s s_d;

    logic       acc;
    logic       prep;
    logic       wr;
    logic       rd;
    logic       pull;
    logic       push;
    logic       stack_full_flag;
    logic       stack_empty_flag;
    logic [1:0] cmp_mask;
    logic [7:0] csr_val;
    logic [3:0] lvl_idx;

    // Access completes once the registered ready is high.
    assign acc  = apb_req_in.psel && apb_req_in.penable && s_q.pready;
    // The first access cycle prepares the answer for the next one.
    assign prep = apb_req_in.psel && apb_req_in.penable && !s_q.pready;
    assign wr   = acc && apb_req_in.pwrite;
    assign rd   = prep && !apb_req_in.pwrite;

    assign stack_full_flag  = (s_q.depth == 3'(`IPN_STACK_DEPTH));
    assign stack_empty_flag = (s_q.depth == 3'h0);

    assign cmp_mask = s_q.stop3_mode ? 2'h0 : s_q.current_mask;

    assign csr_val = {s_q.ctrl_enable_bit, s_q.stop3_mode,
                      stack_empty_flag, stack_full_flag, 2'h0,
                      s_q.current_mask};

    assign pull = wr && (apb_req_in.paddr == `IPN_OFF_CSR)
                  && apb_req_in.pwdata[`IPN_CSR_PULL_BIT];
    assign push = vector_fetch_in && s_q.ctrl_enable_bit;

    always_comb begin
        for (int i = 0; i < `IPN_NUM_SRC; i++) begin
            if (!s_q.ctrl_enable_bit) begin
                cpu_request_out[i] = src_request_in[i];
            end else begin
                cpu_request_out[i] = src_request_in[i]
                                     && (s_q.src_level[i] >= cmp_mask);
            end
        end
    end

    assign pin_level_out = pin_level_in;

    always_comb begin
        s_d         = s_q;
        s_d.prdata  = 32'h0000_0000;
        s_d.pslverr = 1'b0;
        s_d.pready  = prep;
        lvl_idx     = 4'h0;

        if (wr && apb_req_in.paddr >= `IPN_OFF_LVL0
               && apb_req_in.paddr < `IPN_OFF_LVL0 + 12'h010) begin
            lvl_idx = {apb_req_in.paddr[3:2], 2'h0};
            for (int k = 0; k < 4; k++) begin
                s_d.src_level[lvl_idx + 4'(k)] =
                    apb_req_in.pwdata[2*k +: 2];
            end
        end

        if (wr && apb_req_in.paddr == `IPN_OFF_CSR) begin
            s_d.ctrl_enable_bit =
                apb_req_in.pwdata[`IPN_CSR_EN_BIT];
            s_d.stop3_mode = apb_req_in.pwdata[`IPN_CSR_STOP3_BIT];
            s_d.current_mask = apb_req_in.pwdata[1:0];
        end
        if (wr && apb_req_in.paddr == `IPN_OFF_INT_MASK) begin
            s_d.int_mask = apb_req_in.pwdata[2:0];
        end
        if (wr && apb_req_in.paddr == `IPN_OFF_INT_STAT) begin
            s_d.int_stat = s_q.int_stat & ~apb_req_in.pwdata[2:0];
        end

        if (push) begin
            s_d.current_mask = s_q.src_level[vector_src_in];
            s_d.mask_pseudo_stack = {s_q.current_mask,
                                     s_q.mask_pseudo_stack[7:2]};
            if (!stack_full_flag) begin
                s_d.depth = s_q.depth + 3'h1;
            end else begin
                s_d.int_stat[`IPN_EVT_LOST_BIT] = 1'b1;
            end
            s_d.int_stat[`IPN_EVT_PUSH_BIT] = 1'b1;
        end else if (pull) begin
            s_d.current_mask = s_q.mask_pseudo_stack[7:6];
            s_d.mask_pseudo_stack = {s_q.mask_pseudo_stack[5:0], 2'h0};
            if (!stack_empty_flag) begin
                s_d.depth = s_q.depth - 3'h1;
            end else begin
                s_d.int_stat[`IPN_EVT_UNDER_BIT] = 1'b1;
            end
        end

        if (rd) begin
            unique case (apb_req_in.paddr)
                `IPN_OFF_CSR:      s_d.prdata = {24'h0, csr_val};
                `IPN_OFF_STACK:    s_d.prdata = {24'h0,
                                       s_q.mask_pseudo_stack};
                `IPN_OFF_INT_STAT: s_d.prdata = {29'h0, s_q.int_stat};
                `IPN_OFF_INT_MASK: s_d.prdata = {29'h0, s_q.int_mask};
                default: begin
                    if (apb_req_in.paddr >= `IPN_OFF_LVL0
                        && apb_req_in.paddr < `IPN_OFF_LVL0 + 12'h010)
                    begin
                        lvl_idx = {apb_req_in.paddr[3:2], 2'h0};
                        s_d.prdata = {24'h0,
                            s_q.src_level[lvl_idx + 4'h3],
                            s_q.src_level[lvl_idx + 4'h2],
                            s_q.src_level[lvl_idx + 4'h1],
                            s_q.src_level[lvl_idx]};
                    end else begin
                        s_d.pslverr = 1'b1;
                    end
                end
            endcase
        end else if (prep && apb_req_in.pwrite
                    && !(apb_req_in.paddr == `IPN_OFF_CSR
                    || apb_req_in.paddr == `IPN_OFF_INT_STAT
                    || apb_req_in.paddr == `IPN_OFF_INT_MASK
                    || (apb_req_in.paddr >= `IPN_OFF_LVL0
                    && apb_req_in.paddr < `IPN_OFF_LVL0 + 12'h010))) begin
            s_d.pslverr = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (reset_in) begin
            s_q <= '0;
            s_q.current_mask <= `IPN_RST_MASK;
            s_q.mask_pseudo_stack <= `IPN_RST_STACK;
            s_q.int_mask <= `IPN_RST_INT_MASK;
        end else begin
            s_q <= s_d;
        end
    end

    // Ready and answer rise together one cycle into the access phase.
    assign apb_rsp_out.prdata  = s_q.prdata;
    assign apb_rsp_out.pslverr = s_q.pslverr;
    assign apb_rsp_out.pready  = s_q.pready;

    // Level interrupt from the unmasked event bits.
    assign irq_out = |(s_q.int_stat & s_q.int_mask);

    property p_push_mask;
        @(posedge core_clk_in) disable iff (reset_in)
        push |=> s_q.current_mask == $past(s_q.src_level[vector_src_in]);
    endproperty
    AST_PUSH_LOADS_MASK: assert property (p_push_mask)
        else $error("Mask not loaded on vector fetch.");

    AST_PUSH_SHIFTS_OLD: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        push |=> s_q.mask_pseudo_stack[7:6] == $past(s_q.current_mask))
        else $error("Old mask not pushed.");

    AST_PULL_RESTORES: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        (pull && !push) |=>
            s_q.current_mask == $past(s_q.mask_pseudo_stack[7:6]))
        else $error("Pull did not restore mask.");

    AST_PULL_ZEROS: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        (pull && !push) |=> s_q.mask_pseudo_stack[1:0] == 2'h0)
        else $error("Pull did not shift in zeros.");

    AST_GATE: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        (s_q.ctrl_enable_bit && !s_q.stop3_mode && src_request_in[0]
         && s_q.src_level[0] < s_q.current_mask) |-> !cpu_request_out[0])
        else $error("Low level request passed.");

    AST_BYPASS: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        !s_q.ctrl_enable_bit |-> cpu_request_out == src_request_in)
        else $error("Disabled controller gated requests.");

    AST_STOP3: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        (s_q.ctrl_enable_bit && s_q.stop3_mode)
            |-> cpu_request_out == src_request_in)
        else $error("Stop3 did not use zero mask.");

    sequence s_four_pushes;
        (stack_empty_flag && push) ##1 push ##1 push ##1 push;
    endsequence
    AST_FULL_AFTER_FOUR: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        s_four_pushes |=> stack_full_flag)
        else $error("Full flag missing after four pushes.");

    AST_EMPTY_REACH: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        (s_q.depth == 3'h1 && pull && !push) |=> stack_empty_flag)
        else $error("Empty flag missing after last pull.");

    AST_READY_WAIT: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        prep |=> apb_rsp_out.pready)
        else $error("Ready missing after first access cycle.");

    AST_READY_DROPS: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        acc |=> !apb_rsp_out.pready)
        else $error("Ready stayed high after access.");

    AST_LEVEL_WRITE: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        (wr && apb_req_in.paddr == `IPN_OFF_LVL0)
            |=> s_q.src_level[3:0] == $past(apb_req_in.pwdata[7:0]))
        else $error("Level write did not land.");

    AST_GATE_PASS: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        (s_q.ctrl_enable_bit && !s_q.stop3_mode && src_request_in[0]
         && s_q.src_level[0] >= s_q.current_mask) |-> cpu_request_out[0])
        else $error("Qualified request was blocked.");

    AST_PUSH_EVENT: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        push |=> s_q.int_stat[`IPN_EVT_PUSH_BIT])
        else $error("Push event not flagged.");

    AST_FULL_ON_FOURTH: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        (push && s_q.depth == 3'h3) |=> stack_full_flag)
        else $error("Full flag missing after fourth entry.");

    AST_OVERFLOW_DROPS: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        (push && stack_full_flag) |=> stack_full_flag
            && s_q.mask_pseudo_stack[5:0]
               == $past(s_q.mask_pseudo_stack[7:2]))
        else $error("Oldest entry not dropped while full.");

    AST_UNDERFLOW_STAYS: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        (pull && !push && stack_empty_flag) |=> stack_empty_flag
            && s_q.int_stat[`IPN_EVT_UNDER_BIT])
        else $error("Pull while empty mishandled.");

    AST_WRITE_NO_PUSH: assert property (
        @(posedge core_clk_in) disable iff (reset_in)
        (wr && apb_req_in.paddr == `IPN_OFF_CSR && !push
         && !apb_req_in.pwdata[`IPN_CSR_PULL_BIT])
            |=> s_q.mask_pseudo_stack == $past(s_q.mask_pseudo_stack))
        else $error("Mask write changed the stack.");

endmodule : ipn_priority_nesting_ctrl

// ===== core/ipn_defines.svh
/*
 * Offsets, field positions, reset values and sizes of the interrupt
 * priority nesting controller.
 * Assumes it is included by its bare name after the package.
 */
`ifndef IPN_DEFINES_SVH
`define IPN_DEFINES_SVH

`define IPN_NUM_SRC        16
`define IPN_NUM_LVL_REGS   4
`define IPN_STACK_DEPTH    4
`define IPN_OFF_CSR        12'h000
`define IPN_OFF_STACK      12'h004
`define IPN_OFF_INT_STAT   12'h008
`define IPN_OFF_INT_MASK   12'h00c
`define IPN_OFF_LVL0       12'h010
`define IPN_CSR_MASK_LO    0
`define IPN_CSR_PULL_BIT   3
`define IPN_CSR_FULL_BIT   4
`define IPN_CSR_EMPTY_BIT  5
`define IPN_CSR_STOP3_BIT  6
`define IPN_CSR_EN_BIT     7
`define IPN_EVT_PUSH_BIT   0
`define IPN_EVT_LOST_BIT   1
`define IPN_EVT_UNDER_BIT  2
`define IPN_RST_MASK       2'h0
`define IPN_RST_STACK      8'h00
`define IPN_RST_INT_MASK   3'h0

`endif

// ===== core/ipn_pkg.sv
/*
 * Types of the interrupt priority nesting controller.
 * Assumes nothing beyond the defines header.
 */
package ipn_pkg;

    typedef logic [1:0] ipn_lvl_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } ipn_apb_req_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } ipn_apb_rsp_s;

    typedef struct packed {
        logic [15:0][1:0] src_level;
        ipn_lvl_t         current_mask;
        logic [7:0]       mask_pseudo_stack;
        logic [2:0]       depth;
        logic             ctrl_enable_bit;
        logic             stop3_mode;
        logic [2:0]       int_stat;
        logic [2:0]       int_mask;
        logic [31:0]      prdata;
        logic             pslverr;
        logic             pready;
    } ipn_state_s;

endpackage : ipn_pkg

// ===== verification/ipn_cpu_model.sv
/* CPU-side model: on command, fetches the vector of a gated request.
 * Assumes gated requests from the controller on core_clk_in. */
module ipn_cpu_model (
    // Clock and reset.
    input  wire logic        core_clk_in,
    input  wire logic        reset_in,
    // Controller side and command.
    input  wire logic [15:0] cpu_request_in,
    input  wire logic        take_in,
    output logic             vector_fetch_out,
    output logic [3:0]       vector_src_out
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge core_clk_in) begin
        vector_fetch_out <= 1'b0;
        vector_src_out   <= ~vector_src_out;
        if (reset_in) begin
            vector_src_out <= 4'h0;
        end else if (take_in && |cpu_request_in) begin
            vector_fetch_out <= 1'b1;
            for (int i = 15; i >= 0; i--) begin
                if (cpu_request_in[i]) vector_src_out <= 4'(i);
            end
        end
    end
endmodule : ipn_cpu_model

// ===== verification/test_interrupt_priority_nesting_ctrl.sv
/* Bench of the priority nesting controller: APB tasks, read monitor,
 * pass-through, mask sweep, nesting, events and pulls.
 * Assumes the CPU model is compiled before it. */
`include "ipn_defines.svh"
module test_interrupt_priority_nesting_ctrl
    import ipn_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk = 1'b0;
    logic         rst = 1'b1;
    ipn_apb_req_s req;
    ipn_apb_rsp_s rsp;
    logic [15:0]  src;
    logic [15:0]  gated;
    logic [15:0]  e;
    logic [3:0]   vsrc;
    logic         fetch;
    logic         take;
    logic         pin;
    logic         pin_o;
    logic         irq;
    logic [32:0]  exp_q[$];
    logic [1:0]   lvl[16];
    logic [1:0]   mask;
    logic [7:0]   stk;
    logic [2:0]   evt;
    logic [31:0]  d;
    int           depth;
    int           err_count = 0;
    int           checked = 0;
    int           cycles = 0;

    always #2 clk = ~clk;

    ipn_priority_nesting_ctrl i_ipn_priority_nesting_ctrl (
        .core_clk_in(clk), .reset_in(rst), .apb_req_in(req),
        .apb_rsp_out(rsp), .src_request_in(src), .vector_fetch_in(fetch),
        .vector_src_in(vsrc), .pin_level_in(pin), .cpu_request_out(gated),
        .pin_level_out(pin_o), .irq_out(irq));

    ipn_cpu_model i_ipn_cpu_model (
        .core_clk_in(clk), .reset_in(rst), .cpu_request_in(gated),
        .take_in(take), .vector_fetch_out(fetch), .vector_src_out(vsrc));

    task automatic conclude();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic chk(input logic [32:0] got, input logic [32:0] x);
        checked++;
        if (got !== x) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, x);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] v,
                      input logic w = 1'b1);
        req <= '{1'b1, 1'b0, w, a, v};
        @(posedge clk);
        req.penable <= 1'b1;
        @(posedge clk);
        while (rsp.pready !== 1'b1) @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [32:0] x);
        exp_q.push_back(x);
        wr(a, 32'h0, 1'b0);
    endtask : rd

    function automatic logic [32:0] csr(input logic en);
        return {25'h0, en, 1'b0, depth == 0, depth == 4, 2'h0, mask};
    endfunction : csr

    task automatic vec(input int k);
        src <= 16'h1 << k;
        @(posedge clk);
        take <= 1'b1;
        @(negedge clk);
        chk(33'(gated), 33'(16'h1 << k));
        @(posedge clk);
        take <= 1'b0;
        src  <= 16'h0;
        repeat (2) @(posedge clk);
        evt[0] = 1'b1;
        evt[1] = evt[1] | (depth == 4);
        stk = {mask, stk[7:2]};
        depth = (depth == 4) ? 4 : depth + 1;
        mask = lvl[k];
    endtask : vec

    task automatic pull();
        wr(`IPN_OFF_CSR, 32'h88 | ($urandom & 32'h3));
        evt[2] = evt[2] | (depth == 0);
        mask = stk[7:6];
        stk = {stk[5:0], 2'h0};
        depth = (depth == 0) ? 0 : depth - 1;
    endtask : pull

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            conclude();
        end
    end

    always @(negedge clk) begin
        if (req.psel && req.penable && !req.pwrite
            && rsp.pready === 1'b1 && exp_q.size() > 0) begin
            chk({rsp.pslverr, rsp.prdata}, exp_q.pop_front());
        end
    end

    initial begin
        req = '0; src = 16'h0; take = 1'b0; pin = 1'b0;
        mask = 2'h0; stk = 8'h0; evt = 3'h0; depth = 0;
        void'($urandom(32'h429423ca));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd(`IPN_OFF_CSR, csr(1'b0));
        rd(`IPN_OFF_STACK, 33'h0);
        repeat (4) begin
            src <= 16'($urandom);
            pin <= 1'($urandom);
            @(negedge clk);
            chk(33'(gated), 33'(src));
            chk(33'(pin_o), 33'(pin));
            @(posedge clk);
        end
        for (int r = 0; r < 4; r++) begin
            d = $urandom;
            wr(`IPN_OFF_LVL0 + 12'(r * 4), d);
            for (int j = 0; j < 4; j++) lvl[4 * r + j] = d[2 * j +: 2];
            rd(`IPN_OFF_LVL0 + 12'(r * 4), 33'(d[7:0]));
        end
        src <= 16'hffff;
        for (int m = 0; m < 5; m++) begin
            wr(`IPN_OFF_CSR, (m == 4) ? 32'hc3 : 32'h80 | 32'(m));
            @(negedge clk);
            for (int k = 0; k < 16; k++) e[k] = (m == 4) || (lvl[k] >= m);
            chk(33'(gated), 33'(e));
            @(posedge clk);
        end
        rd(12'h020, {1'b1, 32'h0});
        src <= 16'h0;
        wr(`IPN_OFF_CSR, 32'h81);
        mask = 2'h1;
        rd(`IPN_OFF_STACK, 33'h0);
        wr(`IPN_OFF_LVL0, 32'hf9);
        wr(`IPN_OFF_LVL0 + 12'h4, 32'h03);
        for (int k = 0; k < 5; k++) lvl[k] = (k < 2) ? 2'(k + 1) : 2'h3;
        for (int k = 0; k < 5; k++) begin
            vec(k);
            rd(`IPN_OFF_CSR, csr(1'b1));
            rd(`IPN_OFF_STACK, 33'(stk));
        end
        rd(`IPN_OFF_INT_STAT, 33'(evt));
        wr(`IPN_OFF_INT_MASK, 32'h7);
        @(negedge clk);
        chk(33'(irq), 33'h1);
        @(posedge clk);
        wr(`IPN_OFF_INT_STAT, 32'h7);
        evt = 3'h0;
        rd(`IPN_OFF_INT_STAT, 33'h0);
        for (int i = 0; i < 5; i++) begin
            pull();
            rd(`IPN_OFF_CSR, csr(1'b1));
            rd(`IPN_OFF_STACK, 33'(stk));
        end
        rd(`IPN_OFF_INT_STAT, 33'(evt));
        @(negedge clk);
        chk(33'(irq), 33'h1);
        @(posedge clk);
        conclude();
    end
endmodule : test_interrupt_priority_nesting_ctrl
